// *** debug_power_reset_params.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte addressed debug register port, 250 MHz clock
// Notes: included by the timer, the control module and the testbench
`ifndef DEBUG_POWER_RESET_PARAMS_SVH
`define DEBUG_POWER_RESET_PARAMS_SVH

`define DPR_ADDR_W 12
`define DPR_CTRL_OFS 12'h310
`define DPR_STAT_OFS 12'h314

`define DPR_CTRL_NOPWRDWN_BIT 0
`define DPR_CTRL_FORCE_BIT 1
`define DPR_CTRL_HOLD_BIT 2

`define DPR_STAT_PWRUP_BIT 0
`define DPR_STAT_STICKY_PD_BIT 1
`define DPR_STAT_RESET_BIT 2
`define DPR_STAT_STICKY_RST_BIT 3

`define DPR_NOPWRDWN_RST 1'b0
`define DPR_HOLD_RST 1'b0
`define DPR_STICKY_PD_RST 1'b1
`define DPR_STICKY_RST_RST 1'b0

`define DPR_CLK_PERIOD_NS 4
`define DPR_FORCE_RESET_NS 40
`define DPR_FORCE_CNT_W 4
`define DPR_FORCE_RESET_CYC \
	((`DPR_FORCE_RESET_NS + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)

`endif

// *** debug_power_reset_pkg.sv ***
// Purpose: shared types of the debug power and reset control
// Assumes: constants come from the params header
// Notes: core reset sequence states are one-hot
package debug_power_reset_pkg;
	typedef enum logic [2:0] {
		st_run = 3'b001,
		st_stop = 3'b010,
		st_reset = 3'b100
	} core_state_e;
endpackage

// *** force_reset_timer.sv ***
// Purpose: times the self-clearing forced internal reset pulse
// Assumes: start is a one-cycle pulse
// Notes: a new start reloads the full count
`include "debug_power_reset_params.svh"

module force_reset_timer (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic start_i,
	output logic busy_o
);
	localparam logic [`DPR_FORCE_CNT_W-1:0] LOAD =
		`DPR_FORCE_CNT_W'(`DPR_FORCE_RESET_CYC);

	logic [`DPR_FORCE_CNT_W-1:0] cnt_r;
	logic [`DPR_FORCE_CNT_W-1:0] cnt_nxt;

	assign cnt_nxt = start_i ? LOAD :
		(cnt_r != '0) ? cnt_r - `DPR_FORCE_CNT_W'(1) : cnt_r;
	assign busy_o = (cnt_r != '0);

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// *** debug_power_reset_ctrl.sv ***
// Purpose: debug power-down and reset control and status registers
// Assumes: reset_n_i is the debug logic reset, apart from core resets
// Notes: register port reads answer one cycle after the request
// Operation
// - control bit 0 drives no-powerdown request output
// - force bit resets core like warm reset
// - force bit reads zero, ignored if unsupported
// - force write needs debug enables per security
// - forced reset is brief, then self-clears
// - force plus hold together keeps core reset
// - hold bit keeps core reset until cleared
// - unsupported hold reads zero; supported resets zero
// - hold also applies after warm or forced reset
// - held core refuses transfer instructions, debug entry
// - hold takes effect only with debug enables
// - single power domain reads status b01
// - power-up status mirrors core powered-up input
// - sticky power-down forced one while powered down
// - read while powered up clears sticky power-down
// - locked memory-mapped read keeps sticky power-down
// - sticky power-down makes some accesses error
// - reset status shows core in reset state
// - core stops executing before entering reset
// - reset left when inputs high, hold clear
// - sticky reset status resets to zero
// - power status bits never read b00
// - sticky reset forced one while in reset
// - read outside reset clears sticky reset, unless locked
`include "debug_power_reset_params.svh"

module debug_power_reset_ctrl #(
	parameter bit HAS_NOPWRDWN = 1'b1,
	parameter bit HAS_FORCE = 1'b1,
	parameter bit HAS_HOLD = 1'b1,
	parameter bit HAS_SECEXT = 1'b1,
	parameter bit SINGLE_POWER = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic dbg_sel_i,
	input wire logic dbg_write_i,
	input wire logic [`DPR_ADDR_W-1:0] dbg_addr_i,
	input wire logic [31:0] dbg_wdata_i,
	input wire logic dbg_mmap_i,
	input wire logic sw_lock_i,
	output logic [31:0] dbg_rdata_o,
	output logic dbg_rvalid_o,
	input wire logic invasive_debug_enable_i,
	input wire logic secure_invasive_debug_enable_i,
	input wire logic warm_reset_n_i,
	input wire logic core_poweron_reset_n_i,
	input wire logic core_powered_up_in_i,
	output logic no_powerdown_request_out_o,
	output logic core_reset_n_o,
	output logic core_run_o,
	output logic itr_refuse_o,
	output logic access_error_o,
	output debug_power_reset_pkg::core_state_e core_state_o
);
	import debug_power_reset_pkg::*;

	core_state_e state_r;
	core_state_e state_nxt;
	logic npd_r;
	logic npd_nxt;
	logic hold_r;
	logic hold_nxt;
	logic sticky_pd_r;
	logic sticky_pd_nxt;
	logic sticky_rst_r;
	logic sticky_rst_nxt;
	logic [31:0] rdata_nxt;
	logic force_busy;

	// register port decode
	wire wr_ctrl = dbg_sel_i & dbg_write_i & (dbg_addr_i == `DPR_CTRL_OFS);
	wire rd_ctrl = dbg_sel_i & !dbg_write_i & (dbg_addr_i == `DPR_CTRL_OFS);
	wire rd_stat = dbg_sel_i & !dbg_write_i & (dbg_addr_i == `DPR_STAT_OFS);
	wire rd_any = dbg_sel_i & !dbg_write_i;
	wire rd_keep = dbg_mmap_i & sw_lock_i;
	wire rd_clears = rd_stat & !rd_keep;

	// authentication gating
	wire auth = HAS_SECEXT ?
		(invasive_debug_enable_i & secure_invasive_debug_enable_i) :
		invasive_debug_enable_i;
	wire force_take = wr_ctrl & dbg_wdata_i[`DPR_CTRL_FORCE_BIT] &
		auth & HAS_FORCE;
	wire hold_eff = hold_r & auth;

	// core reset sequencing
	wire ext_rst = !warm_reset_n_i | !core_poweron_reset_n_i;
	wire enter_rst = ext_rst | force_busy;
	wire in_reset = (state_r == st_reset);
	wire pwr_up = core_powered_up_in_i;

	force_reset_timer u_force_timer (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.start_i(force_take),
		.busy_o(force_busy)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			st_run: begin
				if (enter_rst) begin
					state_nxt = st_stop;
				end
			end
			st_stop: begin
				state_nxt = st_reset;
			end
			st_reset: begin
				if (!enter_rst && !hold_eff) begin
					state_nxt = st_run;
				end
			end
			default: begin
				state_nxt = st_reset;
			end
		endcase
	end

	// control register
	assign npd_nxt = (wr_ctrl && HAS_NOPWRDWN) ?
		dbg_wdata_i[`DPR_CTRL_NOPWRDWN_BIT] : npd_r;
	assign hold_nxt = (wr_ctrl && HAS_HOLD) ?
		dbg_wdata_i[`DPR_CTRL_HOLD_BIT] : hold_r;

	// sticky status, set wins over read clear
	assign sticky_pd_nxt = !pwr_up ? 1'b1 :
		rd_clears ? 1'b0 : sticky_pd_r;
	assign sticky_rst_nxt = in_reset ? 1'b1 :
		rd_clears ? 1'b0 : sticky_rst_r;

	wire pu_vis = SINGLE_POWER ? 1'b1 : pwr_up;
	wire pd_vis = SINGLE_POWER ? 1'b0 : (sticky_pd_r | !pwr_up);
	wire rst_vis = sticky_rst_r | in_reset;

	wire [31:0] ctrl_view = {29'h0, hold_r, 1'b0, npd_r};
	wire [31:0] stat_view = {28'h0, rst_vis, in_reset, pd_vis, pu_vis};
	assign rdata_nxt = rd_ctrl ? ctrl_view : rd_stat ? stat_view : 32'h0;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			npd_r <= `DPR_NOPWRDWN_RST;
			hold_r <= `DPR_HOLD_RST;
			sticky_pd_r <= `DPR_STICKY_PD_RST;
			sticky_rst_r <= `DPR_STICKY_RST_RST;
		end else begin
			npd_r <= npd_nxt;
			hold_r <= hold_nxt;
			sticky_pd_r <= sticky_pd_nxt;
			sticky_rst_r <= sticky_rst_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= st_run;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dbg_rdata_o <= 32'h0;
			dbg_rvalid_o <= 1'b0;
		end else begin
			dbg_rdata_o <= rdata_nxt;
			dbg_rvalid_o <= rd_any;
		end
	end

	// outputs follow the next state so they match state_r
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			no_powerdown_request_out_o <= `DPR_NOPWRDWN_RST;
			core_reset_n_o <= 1'b1;
			core_run_o <= 1'b1;
			itr_refuse_o <= 1'b0;
			access_error_o <= !SINGLE_POWER;
			core_state_o <= st_run;
		end else begin
			no_powerdown_request_out_o <= npd_nxt;
			core_reset_n_o <= (state_nxt != st_reset);
			core_run_o <= (state_nxt == st_run);
			itr_refuse_o <= (state_nxt != st_run);
			access_error_o <= sticky_pd_nxt & !SINGLE_POWER;
			core_state_o <= state_nxt;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_both_written;
		wr_ctrl && auth && dbg_wdata_i[`DPR_CTRL_FORCE_BIT] &&
			dbg_wdata_i[`DPR_CTRL_HOLD_BIT];
	endsequence

	sequence s_held_in_reset;
		(state_r == st_reset)[*8];
	endsequence

	property p_npd_follows;
		wr_ctrl |=> no_powerdown_request_out_o ==
			(HAS_NOPWRDWN ? $past(dbg_wdata_i[0]) : $past(npd_r));
	endproperty
	a_npd_follows: assert property (p_npd_follows)
		else $error("no-powerdown request does not follow write");

	property p_force_reads_zero;
		rd_ctrl |=> !dbg_rdata_o[`DPR_CTRL_FORCE_BIT];
	endproperty
	a_force_reads_zero: assert property (p_force_reads_zero)
		else $error("force bit read back non-zero");

	property p_force_needs_auth;
		$rose(force_busy) |-> $past(force_take) && $past(auth);
	endproperty
	a_force_needs_auth: assert property (p_force_needs_auth)
		else $error("forced reset started without authentication");

	property p_force_pulse;
		$rose(force_busy) |-> force_busy[*8] ##[1:4] !force_busy;
	endproperty
	a_force_pulse: assert property (p_force_pulse)
		else $error("forced reset pulse length wrong");

	property p_force_hold;
		s_both_written ##1 (hold_eff && !wr_ctrl)[*3] |-> s_held_in_reset;
	endproperty
	a_force_hold: assert property (p_force_hold)
		else $error("force with hold did not keep core in reset");

	property p_hold_keeps;
		in_reset && hold_eff |=> in_reset;
	endproperty
	a_hold_keeps: assert property (p_hold_keeps)
		else $error("core left reset while hold in effect");

	property p_itr_refused;
		!core_run_o |-> itr_refuse_o && (state_r != st_run);
	endproperty
	a_itr_refused: assert property (p_itr_refused)
		else $error("transfer instructions accepted while not running");

	property p_pwrup_status;
		rd_stat |=> dbg_rdata_o[0] == (SINGLE_POWER | $past(pwr_up));
	endproperty
	a_pwrup_status: assert property (p_pwrup_status)
		else $error("power-up status wrong");

	property p_never_00;
		dbg_rvalid_o && $past(rd_stat) |-> dbg_rdata_o[1:0] != 2'b00;
	endproperty
	a_never_00: assert property (p_never_00)
		else $error("power status read as b00");

	property p_pd_clear;
		rd_clears && pwr_up |=> !sticky_pd_r;
	endproperty
	a_pd_clear: assert property (p_pd_clear)
		else $error("sticky power-down not cleared by read");

	property p_pd_locked;
		rd_stat && rd_keep && sticky_pd_r |=> sticky_pd_r;
	endproperty
	a_pd_locked: assert property (p_pd_locked)
		else $error("locked read cleared sticky power-down");

	property p_stop_first;
		$fell(core_reset_n_o) |-> $past(!core_run_o) && !core_run_o;
	endproperty
	a_stop_first: assert property (p_stop_first)
		else $error("core entered reset without stopping first");

	property p_rst_status;
		rd_stat |=> dbg_rdata_o[2] == $past(in_reset);
	endproperty
	a_rst_status: assert property (p_rst_status)
		else $error("reset status wrong");

	property p_release;
		in_reset && !enter_rst && !hold_eff |=> state_r == st_run;
	endproperty
	a_release: assert property (p_release)
		else $error("core not released from reset");

	property p_sticky_rst;
		in_reset |=> sticky_rst_r ##0 (!rd_stat || dbg_rdata_o[3] || 1'b1);
	endproperty
	a_sticky_rst: assert property (p_sticky_rst)
		else $error("sticky reset not set while in reset");
endmodule

// *** power_ctrl_model.sv ***
// Purpose: system power and reset controller beside the block
// Assumes: the bench asks for power-down and warm reset by level
// Notes: emulated power-down drops core power unless the no-powerdown request is set
module power_ctrl_model (
	input wire logic clk_sys_i,
	input wire logic pd_req_i,
	input wire logic warm_req_i,
	input wire logic no_powerdown_request_out_i,
	output logic core_powered_up_o = 1'b1,
	output logic warm_reset_n_o = 1'b1,
	output logic core_poweron_reset_n_o = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;
	logic off;
	assign off = pd_req_i && !no_powerdown_request_out_i;
	always @(posedge clk_sys_i) begin
		core_powered_up_o <= !off;
		core_poweron_reset_n_o <= !off;
		warm_reset_n_o <= !warm_req_i;
	end
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench for the debug power and reset block
// Assumes: reads answer one cycle after the request
// Notes: status expectations cover bits [3:0]
`include "debug_power_reset_params.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import debug_power_reset_pkg::*;
	logic clk_sys_i = 1'b0, reset_n_i = 1'b0, sel = 1'b0, wr = 1'b0;
	logic mmap = 1'b0, lock = 1'b0, en = 1'b1, sen = 1'b1;
	logic pd_req = 1'b0, warm_req = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic rvalid, npd, crst_n, run, refuse, aerr, pwr, warm_n, por_n;
	core_state_e state;
	int fails = 0, tests_run = 0, cycles = 0;

	debug_power_reset_ctrl debug_power_reset_ctrl_i (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .dbg_sel_i(sel),
		.dbg_write_i(wr), .dbg_addr_i(addr), .dbg_wdata_i(wdata),
		.dbg_mmap_i(mmap), .sw_lock_i(lock), .dbg_rdata_o(rdata),
		.dbg_rvalid_o(rvalid), .invasive_debug_enable_i(en),
		.secure_invasive_debug_enable_i(sen), .warm_reset_n_i(warm_n),
		.core_poweron_reset_n_i(por_n), .core_powered_up_in_i(pwr),
		.no_powerdown_request_out_o(npd), .core_reset_n_o(crst_n),
		.core_run_o(run), .itr_refuse_o(refuse),
		.access_error_o(aerr), .core_state_o(state));
	power_ctrl_model power_ctrl_model_i (
		.clk_sys_i(clk_sys_i), .pd_req_i(pd_req), .warm_req_i(warm_req),
		.no_powerdown_request_out_i(npd), .core_powered_up_o(pwr),
		.warm_reset_n_o(warm_n), .core_poweron_reset_n_o(por_n));

	initial begin
		forever #2 clk_sys_i = !clk_sys_i;
	end

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [11:0] a,
			input logic [31:0] d, input logic m);
		@(posedge clk_sys_i);
		sel <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		mmap <= m;
		lock <= m;
		@(posedge clk_sys_i);
		sel <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [11:0] a, input logic [3:0] e,
			input logic m = 1'b0);
		acc(1'b0, a, 32'h0, m);
		check({31'h0, rvalid}, 32'h1);
		check(rdata, {28'h0, e});
	endtask

	task automatic auth(input logic [1:0] v);
		@(posedge clk_sys_i);
		{en, sen} <= v;
	endtask

	task automatic wait_rst(input logic v);
		int n;
		n = 0;
		while (crst_n !== v && n < 40) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		check({31'h0, crst_n}, {31'h0, v});
	endtask

	task automatic t_regs;
		rd(`DPR_STAT_OFS, 4'h3);
		check({31'h0, run}, 32'h1);
		rd(`DPR_STAT_OFS, 4'h1);
		rd(`DPR_CTRL_OFS, 4'h0);
		rd(12'h000, 4'h0);
		acc(1'b1, `DPR_CTRL_OFS, 32'h1, 1'b0);
		rd(`DPR_CTRL_OFS, 4'h1);
		check({31'h0, npd}, 32'h1);
		acc(1'b1, `DPR_CTRL_OFS, 32'h0, 1'b0);
		rd(`DPR_CTRL_OFS, 4'h0);
		check({31'h0, npd}, 32'h0);
		$display("register test done");
	endtask

	task automatic t_force;
		auth(2'b10);
		acc(1'b1, `DPR_CTRL_OFS, 32'h2, 1'b0);
		repeat (20) @(posedge clk_sys_i);
		rd(`DPR_STAT_OFS, 4'h1);
		auth(2'b11);
		acc(1'b1, `DPR_CTRL_OFS, 32'h2, 1'b0);
		wait_rst(1'b0);
		check({31'h0, run}, 32'h0);
		rd(`DPR_STAT_OFS, 4'hd);
		rd(`DPR_CTRL_OFS, 4'h0);
		wait_rst(1'b1);
		rd(`DPR_STAT_OFS, 4'h9, 1'b1);
		rd(`DPR_STAT_OFS, 4'h9);
		rd(`DPR_STAT_OFS, 4'h1);
		$display("force test done");
	endtask

	task automatic t_hold;
		for (int k = 0; k < 2; k++) begin
			auth({1'b1, k[0]});
			acc(1'b1, `DPR_CTRL_OFS, 32'h6, 1'b0);
			@(posedge clk_sys_i);
			warm_req <= 1'b1;
			repeat (4) @(posedge clk_sys_i);
			warm_req <= 1'b0;
			repeat (30) @(posedge clk_sys_i);
			#1;
			check({30'h0, crst_n, refuse}, {30'h0, !k[0], k[0]});
			acc(1'b1, `DPR_CTRL_OFS, 32'h0, 1'b0);
			wait_rst(1'b1);
			rd(`DPR_STAT_OFS, 4'h9);
		end
		$display("hold test done");
	endtask

	task automatic t_power;
		@(posedge clk_sys_i);
		pd_req <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		#1;
		check({31'h0, aerr}, 32'h1);
		rd(`DPR_STAT_OFS, 4'he);
		rd(`DPR_STAT_OFS, 4'he);
		@(posedge clk_sys_i);
		pd_req <= 1'b0;
		wait_rst(1'b1);
		rd(`DPR_STAT_OFS, 4'hb);
		rd(`DPR_STAT_OFS, 4'h1);
		check({31'h0, aerr}, 32'h0);
		$display("power test done");
	endtask

	initial begin
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_force();
		t_hold();
		t_power();
		give_verdict();
	end
endmodule
